// ### verilog/eau_effective_address.sv
// Effective-address unit: forms operand, branch and vector addresses.
// Assumes the register file contents and decoded fields arrive each cycle
// and that the memory side returns the memory-indirect pointer longword.
`default_nettype none
module eau_effective_address
   import eau_pkg::*;
(
   input  wire logic     clk,
   input  wire logic     rst_n,
   input  wire logic     mode1M,
   input  wire eauRegs_t regs,
   input  wire eauReq_t  req,
   output logic          reqReady,
   input  wire eauPtr_t  ptrRd,
   output eauRsp_t       rsp
);

   ////////////////////////////////////////////////////////////////////////
   // Helper functions

   // Sign-extend an 8-bit field to address width
   function automatic logic [23:0] eauSext8(input logic [7:0] v);
      eauSext8 = {{16{v[7]}}, v};
   endfunction : eauSext8

   // Sign-extend a 16-bit field to address width
   function automatic logic [23:0] eauSext16(input logic [15:0] v);
      eauSext16 = {{8{v[15]}}, v};
   endfunction : eauSext16

   // Step for post-increment and pre-decrement by access size
   function automatic logic [31:0] eauStep(input eauSize_t s);
      case (s)
         EAU_WORD: eauStep = STEP_WORD;
         EAU_LONG: eauStep = STEP_LONG;
         default:  eauStep = STEP_BYTE;
      endcase
   endfunction : eauStep

   // Even alignment and the 1-Mbyte window, shared by all address paths
   function automatic logic [23:0] eauFinal(input logic [23:0] a,
                                            input logic        even,
                                            input logic        narrow);
      logic [23:0] t;
      t = even ? (a & EVEN_MASK) : a;                    // RULE18
      eauFinal = t & (narrow ? MASK_1M : MASK_16M);      // RULE10
   endfunction : eauFinal

   ////////////////////////////////////////////////////////////////////////
   // Register selection

   logic [31:0] regLong;
   logic [15:0] regWord;
   logic [7:0]  regByte;
   logic [31:0] regDirect;

   // Index bit 3 picks the low byte half or the upper word register
   assign regLong = regs[req.regIdx[2:0]];
   assign regWord = req.regIdx[3] ? regLong[31:16] : regLong[15:0]; // RULE1
   assign regByte = req.regIdx[3] ? regLong[7:0] : regLong[15:8];   // RULE1
   // Direct operands are zero-extended to 32 bits
   always_comb begin
      case (req.size)
         EAU_BYTE: regDirect = {24'h00_0000, regByte};   // RULE1
         EAU_WORD: regDirect = {16'h0000, regWord};      // RULE1
         default:  regDirect = regLong;                  // RULE1
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Extension fields

   logic [23:0] dispExt;
   logic [23:0] absAddr;
   logic [31:0] immVal;
   logic [23:0] branchDisp;

   // A 24-bit field is the low part of a 32-bit field with a zero top byte
   assign dispExt = (req.extLen == EAU_LEN16) ? eauSext16(req.ext[15:0])
                                              : req.ext[23:0]; // RULE3 RULE21
   assign branchDisp = (req.extLen == EAU_LEN8) ? eauSext8(req.ext[7:0])
                                                : eauSext16(req.ext[15:0]);
   always_comb begin
      case (req.extLen)
         EAU_LEN8:  absAddr = {SHORT_ABS_TOP, req.ext[7:0]};      // RULE7
         EAU_LEN16: absAddr = eauSext16(req.ext[15:0]);           // RULE8
         default:   absAddr = req.ext[23:0];                      // RULE9
      endcase
   end

   // Immediates keep only the field's own width
   always_comb begin
      case (req.extLen)
         EAU_LEN8:  immVal = {24'h00_0000, req.ext[7:0]};         // RULE11
         EAU_LEN16: immVal = {16'h0000, req.ext[15:0]};           // RULE11
         default:   immVal = req.ext;                             // RULE11
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Address arithmetic

   logic [23:0] dispSum;
   logic [31:0] incReg;
   logic [31:0] decReg;
   logic [23:0] branchSum;
   logic [23:0] ptrAddr;
   logic [23:0] trapAddr;
   logic        wideAccess;

   // Only the low 24 bits of the 32-bit sum matter, so a 24-bit adder does
   assign dispSum = regLong[23:0] + dispExt;                    // RULE3
   assign incReg = regLong + eauStep(req.size);                 // RULE4
   assign decReg = regLong - eauStep(req.size);                 // RULE5
   // The decoder supplies the PC of the next instruction's first byte
   assign branchSum = req.pc + branchDisp;                      // RULE14 RULE15
   assign ptrAddr = {MEM_IND_TOP[7:0], MEM_IND_TOP[7:0], req.ext[7:0]}; // RULE16
   // Vector entries are longwords, four bytes apart
   assign trapAddr = TRAP_VEC_BASE
                   + (24'(req.ext[1:0]) << TRAP_VEC_SHIFT);      // RULE12
   // Byte accesses may sit at odd addresses
   assign wideAccess = (req.size != EAU_BYTE);

   ////////////////////////////////////////////////////////////////////////
   // Mode legality per operation class

   // Refused pairs still answer, so the decoder can trap
   logic modeOk;

   always_comb begin
      case (req.opClass)
         EAU_ARITH:
            modeOk = (req.mode == EAU_REG_DIRECT)
                   || (req.mode == EAU_IMM);                    // RULE19

         EAU_XFER:
            modeOk = (req.mode != EAU_PC_REL)
                   && (req.mode != EAU_MEM_IND)
                   && (req.mode != EAU_TRAP);                   // RULE19

         EAU_BITOP:
            modeOk = (req.mode == EAU_REG_DIRECT)
                   || (req.mode == EAU_REG_IND)
                   || ((req.mode == EAU_ABS)
                       && (req.extLen == EAU_LEN8));            // RULE20

         EAU_BRANCH:
            modeOk = (req.mode == EAU_PC_REL);                  // RULE17

         EAU_JUMP:
            modeOk = (req.mode == EAU_MEM_IND)
                   || (req.mode == EAU_REG_IND)
                   || (req.mode == EAU_ABS);                    // RULE17

         EAU_TRAPOP:
            modeOk = (req.mode == EAU_TRAP);

         default:
            modeOk = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Next response

   eauState_t state;
   eauState_t next_state;
   eauRsp_t   next_rsp;
   logic      isJump;
   logic      take;

   // A memory-indirect request holds the unit until its pointer returns
   assign reqReady = (state == EAU_ST_IDLE);
   assign take = reqReady && req.valid;
   assign isJump = (req.opClass == EAU_JUMP);

   always_comb begin
      // Quiet answer unless a request or pointer comes
      next_rsp = '0;
      next_state = state;

      if (state == EAU_ST_PTR) begin
         // New requests are ignored, not queued, meanwhile
         // Top byte of the pointer longword is discarded
         if (ptrRd.valid) begin
            next_rsp.valid = 1'b1;
            next_rsp.addrValid = 1'b1;
            next_rsp.branch = 1'b1;
            next_rsp.addr = eauFinal(ptrRd.data[23:0], 1'b1,
                                     mode1M);                   // RULE16
            next_state = EAU_ST_IDLE;
         end
      end else if (take && !modeOk) begin
         next_rsp.valid = 1'b1;
         next_rsp.illegal = 1'b1;                               // RULE19
      end else if (take) begin
         next_rsp.valid = 1'b1;
         next_rsp.bitIdx = req.bitNum;                          // RULE13
         case (req.mode)

            // Operand from a register
            EAU_REG_DIRECT: begin
               next_rsp.opValid = 1'b1;
               next_rsp.operand = regDirect;                    // RULE1
            end

            // Address held in the register
            EAU_REG_IND: begin
               next_rsp.addrValid = 1'b1;
               next_rsp.branch = isJump;
               next_rsp.addr = eauFinal(regLong[23:0],
                                        wideAccess || isJump,
                                        mode1M);                // RULE2
            end

            // Register plus displacement
            EAU_REG_DISP: begin
               next_rsp.addrValid = 1'b1;
               next_rsp.addr = eauFinal(dispSum, wideAccess, mode1M);
            end

            // Step after use
            EAU_POST_INC: begin
               // Address and write-back leave in the same cycle
               next_rsp.addrValid = 1'b1;
               next_rsp.addr = eauFinal(regLong[23:0], wideAccess,
                                        mode1M);                // RULE4
               next_rsp.wbEn = 1'b1;                            // RULE22
               next_rsp.wbIdx = req.regIdx[2:0];
               next_rsp.wbData = incReg;                        // RULE4
            end

            // Step before use
            EAU_PRE_DEC: begin
               next_rsp.addrValid = 1'b1;
               next_rsp.addr = eauFinal(decReg[23:0], wideAccess,
                                        mode1M);                // RULE5
               next_rsp.wbEn = 1'b1;                            // RULE22
               next_rsp.wbIdx = req.regIdx[2:0];
               next_rsp.wbData = decReg;                        // RULE5
            end

            // Absolute field, widened
            EAU_ABS: begin
               next_rsp.addrValid = 1'b1;
               next_rsp.branch = isJump;
               next_rsp.addr = eauFinal(absAddr,
                                        wideAccess || isJump,
                                        mode1M);                // RULE10
            end

            // Operand from the code
            EAU_IMM: begin
               next_rsp.opValid = 1'b1;
               next_rsp.operand = immVal;                       // RULE11
            end

            // Branch off the next PC
            EAU_PC_REL: begin
               next_rsp.addrValid = 1'b1;
               next_rsp.branch = 1'b1;
               next_rsp.addr = eauFinal(branchSum, 1'b1, mode1M); // RULE14
            end

            // Jump through a table
            EAU_MEM_IND: begin
               // First the pointer fetch, then the branch target
               next_rsp.addrValid = 1'b1;
               next_rsp.ptrFetch = 1'b1;
               next_rsp.addr = eauFinal(ptrAddr, 1'b1, mode1M); // RULE16
               next_state = EAU_ST_PTR;                         // RULE17
            end

            // Vector table entry
            EAU_TRAP: begin
               next_rsp.addrValid = 1'b1;
               next_rsp.addr = eauFinal(trapAddr, 1'b1, mode1M); // RULE12
            end

            // Unused mode codes
            default: begin
               next_rsp.illegal = 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State and response registers

   // Outputs are registered so address and write-back share one edge
   // Reset leaves the unit idle with a quiet answer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= EAU_ST_IDLE;
         rsp   <= '0;
      end else begin
         state <= next_state;
         rsp   <= next_rsp;                                     // RULE22
      end
   end

endmodule : eau_effective_address
`default_nettype wire

// ### verilog/eau_pkg.sv
// Shared constants and carrier types of the effective-address unit.
// Assumes a decoder that hands over one decoded operand request per cycle.
// Notes on behaviour
// (RULE1) Register-direct picks byte halves, words or 32-bit registers.
// (RULE2) Register-indirect address is the low 24 bits of the register.
// (RULE3) Displacement adds sign-extended 16 or 24-bit offset, keeps 24 bits.
// (RULE4) Post-increment uses the register, then adds 1, 2 or 4 and writes back.
// (RULE5) Pre-decrement subtracts 1, 2 or 4, writes back, uses the result.
// (RULE6) Software should keep the register even for word or long stepping.
// (RULE7) An 8-bit absolute address gets its upper 16 bits forced to one.
// (RULE8) A 16-bit absolute address is sign-extended to 24 bits.
// (RULE9) A 24-bit absolute address is used unchanged.
// (RULE10) In 1-Mbyte modes the upper 4 address bits are dropped.
// (RULE11) Immediates come straight from the code as 8, 16 or 32 bits.
// (RULE12) The trap's 2-bit immediate selects its vector address.
// (RULE13) A 3-bit immediate indexes the bit inside the byte operand.
// (RULE14) Relative branch adds sign-extended 8 or 16-bit offset to the PC.
// (RULE15) The PC used is the address of the next instruction.
// (RULE16) Memory-indirect zero-extends aa8, reads a long, keeps low 24 bits.
// (RULE17) Memory-indirect only for jumps; relative only for branches.
// (RULE18) Word, long and branch addresses get their LSB forced to zero.
// (RULE19) ALU ops: register or immediate; transfers: not relative, indirect.
// (RULE20) Bit ops use register, indirect or short absolute operands.
// (RULE21) Extension fields are 8, 16 or 32 bits; 24-bit ones zero-topped.
// (RULE22) Address and write-back are presented together with the access.
`default_nettype none
package eau_pkg;
   localparam int ADDR_W = 24;
   localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
   localparam logic [31:0] STEP_WORD = 32'h0000_0002;
   localparam logic [31:0] STEP_LONG = 32'h0000_0004;
   localparam logic [15:0] SHORT_ABS_TOP = 16'hffff;
   localparam logic [15:0] MEM_IND_TOP = 16'h0000;
   localparam logic [23:0] MASK_1M = 24'h0f_ffff;
   localparam logic [23:0] MASK_16M = 24'hff_ffff;
   localparam logic [23:0] EVEN_MASK = 24'hff_fffe;
   // Trap vector table base; value arbitrary
   localparam logic [23:0] TRAP_VEC_BASE = 24'h00_0020;
   localparam int TRAP_VEC_SHIFT = 2;

   typedef logic [7:0][31:0] eauRegs_t;
   typedef enum logic [3:0] {
      EAU_REG_DIRECT = 4'h0, EAU_REG_IND = 4'h1, EAU_REG_DISP = 4'h2,
      EAU_POST_INC = 4'h3, EAU_PRE_DEC = 4'h4, EAU_ABS = 4'h5,
      EAU_IMM = 4'h6, EAU_PC_REL = 4'h7, EAU_MEM_IND = 4'h8,
      EAU_TRAP = 4'h9
   } eauMode_t;
   typedef enum logic [1:0] {
      EAU_BYTE = 2'h0, EAU_WORD = 2'h1, EAU_LONG = 2'h2
   } eauSize_t;
   typedef enum logic [1:0] {
      EAU_LEN8 = 2'h0, EAU_LEN16 = 2'h1, EAU_LEN32 = 2'h2
   } eauLen_t;
   typedef enum logic [2:0] {
      EAU_ARITH = 3'h0, EAU_XFER = 3'h1, EAU_BITOP = 3'h2,
      EAU_BRANCH = 3'h3, EAU_JUMP = 3'h4, EAU_TRAPOP = 3'h5
   } eauClass_t;
   typedef enum logic [1:0] { EAU_ST_IDLE = 2'b00, EAU_ST_PTR = 2'b01 }
      eauState_t;

   typedef struct packed {
      logic        valid;
      eauClass_t   opClass;
      eauMode_t    mode;
      eauSize_t    size;
      eauLen_t     extLen;
      logic [3:0]  regIdx;
      logic [31:0] ext;
      logic [2:0]  bitNum;
      logic [23:0] pc;
   } eauReq_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] data;
   } eauPtr_t;

   typedef struct packed {
      logic        valid;
      logic        illegal;
      logic        addrValid;
      logic        ptrFetch;
      logic        branch;
      logic [23:0] addr;
      logic        opValid;
      logic [31:0] operand;
      logic [2:0]  bitIdx;
      logic        wbEn;
      logic [2:0]  wbIdx;
      logic [31:0] wbData;
   } eauRsp_t;
endpackage : eau_pkg
`default_nettype wire

// ### dv/eau_effective_address_checker.sv
// Port assertions for the effective-address unit, bound to its top.
// Assumes mode1M stays put while a pointer longword is awaited.
`default_nettype none
module eau_effective_address_checker
   import eau_pkg::*;
(
   input wire logic     clk,
   input wire logic     rst_n,
   input wire logic     mode1M,
   input wire eauRegs_t regs,
   input wire eauReq_t  req,
   input wire logic     reqReady,
   input wire eauPtr_t  ptrRd,
   input wire eauRsp_t  rsp
);
   eauReq_t     p;
   logic [31:0] pv;
   logic [31:0] pd;
   logic        pt;
   logic        pm;
   logic        pw;
   logic [31:0] st;
   logic [23:0] msk;
   ////////////////////////////////////////
   // Snapshot of the last edge, so each check is a same-cycle compare
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) {p, pv, pd, pt, pm, pw} <= '0;
      else {p, pv, pd, pt, pm, pw} <= {req, regs[req.regIdx[2:0]],
         ptrRd.data, req.valid && reqReady, mode1M, ptrRd.valid && !reqReady};
   end
   // Step size and address mask of the remembered request
   assign st  = (p.size == EAU_BYTE) ? STEP_BYTE
              : (p.size == EAU_WORD) ? STEP_WORD : STEP_LONG;
   assign msk = pm ? MASK_1M : MASK_16M;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////
   rsp_latency_a: assert property (pt |-> rsp.valid)
      else $error("no answer after a taken request");
   post_inc_a: assert property (pt && p.mode == EAU_POST_INC &&
      p.opClass == EAU_XFER |-> rsp.wbEn && rsp.wbData == pv + st)
      else $error("bad post-increment write-back");
   pre_dec_a: assert property (pt && p.mode == EAU_PRE_DEC &&
      p.opClass == EAU_XFER |-> rsp.wbData == pv - st
      && rsp.wbIdx == p.regIdx[2:0])
      else $error("bad pre-decrement write-back");
   short_abs_a: assert property (pt && p.mode == EAU_ABS &&
      p.extLen == EAU_LEN8 && p.opClass == EAU_XFER && !pm
      && p.size == EAU_BYTE |-> rsp.addr == {16'hffff, p.ext[7:0]})
      else $error("bad short absolute address");
   pc_rel_a: assert property (pt && p.opClass == EAU_BRANCH &&
      p.mode == EAU_PC_REL && p.extLen == EAU_LEN8 && !pm |-> rsp.addr ==
      ((p.pc + {{16{p.ext[7]}}, p.ext[7:0]}) & EVEN_MASK))
      else $error("bad relative branch target");
   mask_1m_a: assert property (pt && pm && rsp.addrValid
      |-> rsp.addr[23:20] == 4'h0)
      else $error("upper address bits kept in 1-Mbyte mode");
   even_addr_a: assert property ((rsp.branch ||
      (pt && p.size != EAU_BYTE)) && rsp.addrValid |-> !rsp.addr[0])
      else $error("odd word or branch address");
   illegal_arith_a: assert property (pt && p.opClass == EAU_ARITH &&
      !(p.mode inside {EAU_REG_DIRECT, EAU_IMM})
      |-> rsp.illegal && !rsp.wbEn && !rsp.addrValid)
      else $error("arithmetic memory mode not refused");
   ptr_fetch_a: assert property (pt && p.opClass == EAU_JUMP &&
      p.mode == EAU_MEM_IND |-> (rsp.ptrFetch && rsp.addr[23:8] == 16'h0000)
      ##1 !reqReady)
      else $error("bad pointer fetch");
   ptr_branch_a: assert property (pw |-> rsp.branch &&
      rsp.addr == ({pd[23:1], 1'b0} & msk))
      else $error("bad memory-indirect target");
endmodule : eau_effective_address_checker
bind eau_effective_address eau_effective_address_checker u_chk (
   .clk(clk), .rst_n(rst_n), .mode1M(mode1M), .regs(regs), .req(req),
   .reqReady(reqReady), .ptrRd(ptrRd), .rsp(rsp));
`default_nettype wire

// ### dv/eau_mem_model.sv
// Memory-side partner: answers a pointer fetch with a longword.
// Assumes one pointer fetch in flight; the bench sets the delay.
`default_nettype none
module eau_mem_model
   import eau_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire eauRsp_t    rsp,
   input  wire logic [3:0] delay,
   output eauPtr_t         ptrRd
);
   logic [3:0]  cnt;
   logic [7:0]  loc;
   logic [31:0] last;
   logic [31:0] word;
   logic        hit;
   ////////////////////////////////////////
   // Longword with an odd low byte; idle data flips every cycle
   assign hit   = (cnt == 4'h1);
   assign word  = hit ? {8'hc3, loc ^ 8'h5a, 8'h3c, loc | 8'h01}
                      : ~last;
   assign ptrRd = {hit, word};
   // Delay counter started by each pointer fetch
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) {cnt, loc, last} <= '0;
      else begin
         last <= word;
         if (rsp.valid && rsp.ptrFetch) {cnt, loc} <= {delay, rsp.addr[7:0]};
         else if (cnt != 4'h0) cnt <= cnt - 4'h1;
      end
   end
endmodule : eau_mem_model
`default_nettype wire

// ### dv/eau_effective_address_tb.sv
// Self-checking bench for the effective-address unit.
// Assumes a one-cycle answer and the memory model for pointers.
`default_nettype none
module eau_effective_address_tb
   import eau_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        mode1M = 1'b0;
   eauRegs_t    regs = '0;
   eauReq_t     req = '0;
   logic        reqReady;
   eauPtr_t     ptrRd;
   eauRsp_t     rsp;
   logic [3:0]  delay = 4'h1;
   logic [31:0] seed = 32'h0000_0021;
   int          error_cnt = 0;
   int          checked = 0;
   int          cyc = 0;
   eau_effective_address DUT (.clk(clk), .rst_n(rst_n), .mode1M(mode1M),
      .regs(regs), .req(req), .reqReady(reqReady), .ptrRd(ptrRd), .rsp(rsp));
   eau_mem_model u_mem (.clk(clk), .rst_n(rst_n), .rsp(rsp), .delay(delay),
      .ptrRd(ptrRd));
   ////////////////////////////////////////
   // Clock and a hang limit well above the planned traffic
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   // Legal class and mode pairs, as the unit must accept them
   function automatic logic ok(input eauReq_t r);
      case (r.opClass)
         EAU_ARITH:  return r.mode inside {EAU_REG_DIRECT, EAU_IMM};
         EAU_XFER:   return !(r.mode inside {EAU_PC_REL, EAU_MEM_IND, EAU_TRAP});
         EAU_BITOP:  return r.mode inside {EAU_REG_DIRECT, EAU_REG_IND} ||
                        (r.mode == EAU_ABS && r.extLen == EAU_LEN8);
         EAU_BRANCH: return r.mode == EAU_PC_REL;
         EAU_JUMP:   return r.mode inside {EAU_MEM_IND, EAU_REG_IND, EAU_ABS};
         default:    return r.mode == EAU_TRAP;
      endcase
   endfunction : ok
   // Expected address: sign rules, even forcing, then 1-Mbyte mask
   function automatic logic [23:0] ea(input eauReq_t r, input logic [31:0] v,
                                      input logic [31:0] st, input logic m1);
      logic [23:0] a;
      logic [23:0] s16;
      s16 = {{8{r.ext[15]}}, r.ext[15:0]};
      case (r.mode)
         EAU_REG_DISP: a = v[23:0] + (r.extLen == EAU_LEN16 ? s16 : r.ext[23:0]);
         EAU_PRE_DEC:  a = 24'(v - st);
         EAU_ABS:      a = r.extLen == EAU_LEN8 ? {16'hffff, r.ext[7:0]} :
                           r.extLen == EAU_LEN16 ? s16 : r.ext[23:0];
         EAU_PC_REL:   a = r.pc + (r.extLen == EAU_LEN16 ? s16 :
                           {{16{r.ext[7]}}, r.ext[7:0]});
         EAU_MEM_IND:  a = {16'h0000, r.ext[7:0]};
         EAU_TRAP:     a = TRAP_VEC_BASE + {r.ext[1:0], 2'b00};
         default:      a = v[23:0];
      endcase
      if (r.size != EAU_BYTE || r.opClass inside {EAU_BRANCH, EAU_JUMP,
          EAU_TRAPOP}) a[0] = 1'b0;
      return m1 ? a & 24'h0f_ffff : a;
   endfunction : ea
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   ////////////////////////////////////////
   // One request, driven for a single edge, answer checked the cycle after
   task automatic send(input eauReq_t r);
      logic [31:0] v;
      logic [31:0] st;
      logic [31:0] mk;
      logic [31:0] op;
      int          n;
      v  = regs[r.regIdx[2:0]];
      st = r.size == EAU_BYTE ? 32'h1 : r.size == EAU_WORD ? 32'h2 : 32'h4;
      req = r;
      @(posedge clk);
      #1;
      chk(rsp.valid, 1'b1);
      chk(rsp.illegal, !ok(r));
      if (!ok(r)) chk(rsp.wbEn | rsp.addrValid, 1'b0);
      else begin
         chk(rsp.addrValid, !(r.mode inside {EAU_REG_DIRECT, EAU_IMM}));
         if (!(r.mode inside {EAU_REG_DIRECT, EAU_IMM}))
            chk(rsp.addr, ea(r, v, st, mode1M));
         chk(rsp.opValid, r.mode inside {EAU_REG_DIRECT, EAU_IMM});
         chk(rsp.ptrFetch, r.mode == EAU_MEM_IND);
         mk = {31'h0, r.opClass inside {EAU_BRANCH, EAU_JUMP}};
         chk(rsp.branch, mk[0] && r.mode != EAU_MEM_IND);
         chk(rsp.wbEn, r.mode inside {EAU_POST_INC, EAU_PRE_DEC});
         if (r.mode inside {EAU_POST_INC, EAU_PRE_DEC})
            chk(rsp.wbIdx, r.regIdx[2:0]);
         if (r.mode == EAU_POST_INC) chk(rsp.wbData, v + st);
         if (r.mode == EAU_PRE_DEC) chk(rsp.wbData, v - st);
         mk = r.size == EAU_BYTE ? 32'hff : r.size == EAU_WORD ? 32'hffff : '1;
         op = r.size == EAU_LONG ? v : r.regIdx[3] ^ (r.size == EAU_BYTE) ?
              v >> 8 * r.size + 8 : v;
         if (r.mode == EAU_REG_DIRECT) chk(rsp.operand & mk, op & mk);
         mk = r.extLen == EAU_LEN8 ? 32'hff :
              r.extLen == EAU_LEN16 ? 32'hffff : '1;
         if (r.mode == EAU_IMM) chk(rsp.operand & mk, r.ext & mk);
         if (r.opClass == EAU_BITOP) chk(rsp.bitIdx, r.bitNum);
         if (r.mode == EAU_MEM_IND) begin
            chk(rsp.ptrFetch, 1'b1);
            req.valid = 1'b0;
            n = 0;
            do begin
               @(posedge clk);
               #1;
               n++;
            end while (!rsp.valid && n < 20);
            op = {8'h00, {r.ext[7:1], 1'b0} ^ 8'h5a, 8'h3c, r.ext[7:1], 1'b0};
            if (mode1M) op[23:20] = 4'h0;
            chk(rsp.branch, 1'b1);
            chk(rsp.addr, op[23:0]);
         end
      end
   endtask : send
   task automatic one(input eauClass_t c, input eauMode_t m, input eauSize_t s,
                      input eauLen_t l, input logic [31:0] x,
                      input logic [31:0] v);
      regs[1] = v;
      send('{valid: 1'b1, opClass: c, mode: m, size: s, extLen: l,
             regIdx: 4'h9, ext: x, bitNum: 3'h5, pc: 24'h00_0100});
   endtask : one
   // Random mix of all classes and modes, refusals included
   task automatic rand_run(input int n);
      eauReq_t     r;
      logic [31:0] t;
      for (int i = 0; i < n; i++) begin
         r = '{valid: 1'b1, opClass: eauClass_t'(3'(rnd() % 6)),
               mode: eauMode_t'(4'(rnd() % 10)), size: eauSize_t'(2'(rnd() % 3)),
               extLen: eauLen_t'(2'(rnd() % 3)), regIdx: 4'(rnd()),
               ext: rnd(), bitNum: 3'(rnd()), pc: 24'(rnd())};
         if (r.mode == EAU_PC_REL && r.extLen == EAU_LEN32) r.extLen = EAU_LEN16;
         if (r.mode == EAU_REG_DISP && r.extLen == EAU_LEN8) r.extLen = EAU_LEN16;
         if (r.opClass == EAU_BITOP) r.size = EAU_BYTE;
         t = rnd();
         mode1M = t[0];
         delay = {2'b00, t[2:1]} + 4'h1;
         t = rnd();
         if (r.mode inside {EAU_POST_INC, EAU_PRE_DEC} && r.size != EAU_BYTE)
            t[0] = 1'b0;
         regs[r.regIdx[2:0]] = t;
         send(r);
      end
   endtask : rand_run
   task automatic do_reset();
      req.valid = 1'b0;
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(rsp === '0, 1'b1);
      chk(reqReady, 1'b1);
      rst_n = 1'b1;
   endtask : do_reset
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////
   // Corners first, then random traffic around a mid-run reset
   initial begin
      do_reset();
      one(EAU_XFER, EAU_PRE_DEC, EAU_BYTE, EAU_LEN8, 32'h0, 32'h0);
      one(EAU_XFER, EAU_POST_INC, EAU_LONG, EAU_LEN8, 32'h0, '1 - 32'h3);
      one(EAU_XFER, EAU_ABS, EAU_BYTE, EAU_LEN8, 32'h0, 32'h0);
      one(EAU_XFER, EAU_ABS, EAU_WORD, EAU_LEN16, 32'h8001, 32'h0);
      one(EAU_XFER, EAU_ABS, EAU_BYTE, EAU_LEN32, 32'h00ff_ffff, 32'h0);
      one(EAU_XFER, EAU_REG_DISP, EAU_LONG, EAU_LEN16, 32'h8000, 32'h1_0003);
      one(EAU_BRANCH, EAU_PC_REL, EAU_BYTE, EAU_LEN8, 32'h80, 32'h0);
      one(EAU_BRANCH, EAU_PC_REL, EAU_BYTE, EAU_LEN16, 32'h7fff, 32'h0);
      one(EAU_ARITH, EAU_REG_IND, EAU_BYTE, EAU_LEN8, 32'h0, 32'h0);
      one(EAU_BRANCH, EAU_MEM_IND, EAU_BYTE, EAU_LEN8, 32'h0, 32'h0);
      for (int k = 0; k < 4; k++)
         one(EAU_TRAPOP, EAU_TRAP, EAU_BYTE, EAU_LEN8, 32'(k), 32'h0);
      delay = 4'h5;
      one(EAU_JUMP, EAU_MEM_IND, EAU_WORD, EAU_LEN8, 32'hff, 32'h0);
      mode1M = 1'b1;
      one(EAU_XFER, EAU_REG_IND, EAU_BYTE, EAU_LEN8, 32'h0, 32'h00ff_ffff);
      $display("test corners done");
      rand_run(300);
      $display("test random done");
      do_reset();
      rand_run(300);
      $display("test reset and random done");
      report_and_stop();
   end
endmodule : eau_effective_address_tb
`default_nettype wire
